// *** alu_status_flags_pkg.sv ***
// constants and types for the alu status flag block
package alu_status_flags_pkg;
	localparam int data_width = 8;
	localparam int flag_neg_bit = 4;
	localparam int flag_ovf_bit = 3;
	localparam int flag_zero_bit = 2;
	localparam int flag_dc_bit = 1;
	localparam int flag_carry_bit = 0;
	localparam int nibble_msb = 3;
	localparam logic [7:0] flag_impl_mask = 8'h1f;
	localparam logic [7:0] data_zero = 8'h00;
	localparam logic [11:0] alu_flags_addr = 12'hfd8;

	typedef enum logic [3:0] {
		add_to_file_op,
		add_literal_op,
		sub_from_literal_op,
		sub_file_op,
		rotate_right_op,
		rotate_left_op,
		logic_op,
		file_wipe_op,
		bit_drop_op,
		bit_raise_op,
		nibble_exchange_op,
		file_to_file_op,
		work_to_file_op,
		move_op
	} alu_op_t;

	typedef enum logic [2:0] {
		inherent_mode,
		literal_mode,
		direct_mode,
		indirect_mode,
		indexed_offset_mode
	} addr_mode_t;
endpackage : alu_status_flags_pkg

// *** alu_status_flags.sv ***
// alu status flag register with flag update logic and write-back steering
//
// Overview of operation
// (RULE_01) When an instruction that sets arithmetic flags targets the flag register, its result is dropped and only the flags update.
// (RULE_02) A clear of the flag register sets zero and keeps the other flags, reading back as 000u u1uu.
// (RULE_03) Software should alter the flag register only with bit clear, bit set, nibble swap or the two move instructions.
// (RULE_04) In subtraction carry and digit carry are active-low borrows, since subtraction adds the two's complement.
// (RULE_05) The negative flag at bit 4 follows the result's top bit.
// (RULE_06) The overflow flag at bit 3 is set when a signed result overflows seven bits of magnitude.
// (RULE_07) The zero flag at bit 2 is set when an arithmetic or logic result is zero.
// (RULE_08) For add and subtract operations the digit carry flag at bit 1 takes the carry out of bit 3.
// (RULE_09) For rotates the digit carry flag is loaded from bit 4 or bit 3 of the source.
// (RULE_10) For add and subtract operations the carry flag at bit 0 takes the carry out of the top bit.
// (RULE_11) For rotates the carry flag is loaded from the source's high or low bit, per direction.
// (RULE_12) Inherent, literal, direct and indirect addressing are offered, indexed literal offset only with the extended set enabled.
// (RULE_13) Flags update in the same cycle as the instruction's write-back.
`timescale 1ns/1ps
module alu_status_flags (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_exec,
	input wire alu_status_flags_pkg::alu_op_t i_op,
	input wire logic [7:0] i_opnd_a,
	input wire logic [7:0] i_opnd_b,
	input wire logic [7:0] i_logic_result,
	input wire logic [11:0] i_dest_addr,
	input wire logic i_dest_file,
	input wire logic [2:0] i_bit_sel,
	input wire logic i_extended_set_enable,
	input wire alu_status_flags_pkg::addr_mode_t i_addr_mode,
	output logic [7:0] o_alu_flags,
	output logic [7:0] o_result,
	output logic o_result_we,
	output logic o_mode_legal
);
	import alu_status_flags_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// arithmetic core

	logic [4:0] flags;
	logic [4:0] next_flags;

	// adds with carry in, returning {carry out, digit carry, sum}
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		return {hi[4], lo[4], hi[3:0], lo[3:0]};
	endfunction : add8

	wire is_add = (i_op == add_to_file_op) || (i_op == add_literal_op);
	// sub_from_literal: literal - w; sub_file: file - w; b is always the subtrahend
	wire is_sub = (i_op == sub_from_literal_op) || (i_op == sub_file_op);
	wire is_arith = is_add || is_sub;
	wire is_rot = (i_op == rotate_right_op) || (i_op == rotate_left_op);
	wire is_logic = (i_op == logic_op);
	wire is_wipe = (i_op == file_wipe_op);

	// two's complement add: invert b, carry in one, so carry reads as not-borrow
	wire [7:0] addend = is_sub ? ~i_opnd_b : i_opnd_b; // RULE_04
	wire [9:0] sum_pack = add8(i_opnd_a, addend, is_sub); // RULE_04
	wire [7:0] sum = sum_pack[7:0];
	wire sum_carry = sum_pack[9];
	wire sum_dc = sum_pack[8];
	wire sum_ovf = (i_opnd_a[7] == addend[7]) && (sum[7] != i_opnd_a[7]);

	// rotate through carry
	wire [7:0] rot_right = {flags[flag_carry_bit], i_opnd_a[7:1]};
	wire [7:0] rot_left = {i_opnd_a[6:0], flags[flag_carry_bit]};

	wire [7:0] swap_val = {i_opnd_a[3:0], i_opnd_a[7:4]};
	wire [7:0] bit_mask = 8'h01 << i_bit_sel;

	logic [7:0] alu_out;
	always_comb begin
		case (i_op)
			add_to_file_op, add_literal_op, sub_from_literal_op, sub_file_op: alu_out = sum;
			rotate_right_op: alu_out = rot_right;
			rotate_left_op: alu_out = rot_left;
			logic_op: alu_out = i_logic_result;
			file_wipe_op: alu_out = data_zero;
			bit_drop_op: alu_out = i_opnd_a & ~bit_mask;
			bit_raise_op: alu_out = i_opnd_a | bit_mask;
			nibble_exchange_op: alu_out = swap_val;
			default: alu_out = i_opnd_a;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// flag update

	wire affects_flags = is_arith || is_rot || is_logic || is_wipe;
	wire targets_flags = i_dest_file && (i_dest_addr == alu_flags_addr);
	// flag-affecting ops to the flag register keep the result out
	wire drop_result = targets_flags && affects_flags; // RULE_01
	// rotate direction decides which source bits feed carry and digit carry
	wire rot_c = (i_op == rotate_right_op) ? i_opnd_a[0] : i_opnd_a[7]; // RULE_11
	wire rot_dc = (i_op == rotate_right_op) ? i_opnd_a[flag_neg_bit] : i_opnd_a[nibble_msb]; // RULE_09

	always_comb begin
		next_flags = flags;
		// direct writes of plain ops land in the implemented bits only
		if (targets_flags && !affects_flags)
			next_flags = alu_out[4:0]; // RULE_03
		if (affects_flags) begin
			next_flags[flag_zero_bit] = (alu_out == data_zero); // RULE_07 RULE_02
			if (!is_wipe)
				next_flags[flag_neg_bit] = alu_out[data_width-1]; // RULE_05
		end
		if (is_arith) begin
			next_flags[flag_ovf_bit] = sum_ovf; // RULE_06
			next_flags[flag_dc_bit] = sum_dc; // RULE_08
			next_flags[flag_carry_bit] = sum_carry; // RULE_10
		end
		if (is_rot) begin
			next_flags[flag_dc_bit] = rot_dc; // RULE_09
			next_flags[flag_carry_bit] = rot_c; // RULE_11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// addressing mode check

	// indexed literal offset only exists with the extended set
	wire mode_ok = (i_addr_mode != indexed_offset_mode) || i_extended_set_enable; // RULE_12

	////////////////////////////////////////////////////////////////////////
	// registers: flags and write-back commit on the same edge

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			// flags are undefined at power-up; zero chosen for determinism
			flags <= '0;
		end else if (i_exec && mode_ok) begin
			flags <= next_flags; // RULE_13
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_result <= data_zero;
			o_result_we <= 1'b0;
			o_mode_legal <= 1'b1;
		end else begin
			o_result <= alu_out;
			o_result_we <= i_exec && mode_ok && !drop_result && !targets_flags; // RULE_01 RULE_13
			o_mode_legal <= mode_ok;
		end
	end

	// upper bits unimplemented, read zero
	assign o_alu_flags = {3'b000, flags} & flag_impl_mask;

endmodule : alu_status_flags

// *** alu_status_flags_monitor.sv ***
// port assertions for the alu status flag block
`timescale 1ns/1ps
module alu_status_flags_monitor import alu_status_flags_pkg::*; (
	input logic i_mclk, i_rst, i_exec, i_dest_file, i_extended_set_enable, o_result_we, o_mode_legal,
	input alu_op_t i_op,
	input addr_mode_t i_addr_mode,
	input logic [11:0] i_dest_addr,
	input logic [7:0] i_opnd_a, i_opnd_b, o_alu_flags, o_result
);
	wire go = i_exec && (i_addr_mode != indexed_offset_mode || i_extended_set_enable);
	wire to_fl = i_dest_file && i_dest_addr == alu_flags_addr;
	wire add_w = go && !i_dest_file && i_op == add_literal_op;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	chk_we_strobe: assert property (go && !to_fl |=> o_result_we)
		else $error("no strobe");
	chk_flag_dest: assert property (go && to_fl |=> !o_result_we)
		else $error("flag dest written");
	chk_mode_refuse: assert property (i_exec && !go
		|=> !o_mode_legal && !o_result_we && $stable(o_alu_flags)) else $error("mode taken");
	chk_flags_hold: assert property (!i_exec |=> $stable(o_alu_flags))
		else $error("flags moved");
	chk_neg_zero: assert property (add_w
		|=> o_alu_flags[4] == o_result[7] && o_alu_flags[2] == (o_result == 8'h00)) else $error("n or z");
	chk_add_carry: assert property (add_w |=> o_alu_flags[1:0] ==
		{$past(i_opnd_a[3:0]) + $past(i_opnd_b[3:0]) > 5'h0f, $past(i_opnd_a) + $past(i_opnd_b) > 9'h0ff})
		else $error("carry");
	chk_wipe_zero: assert property (go && to_fl && i_op == file_wipe_op
		|=> o_alu_flags == ($past(o_alu_flags) & 8'h1b | 8'h04)) else $error("wipe");
	chk_rotate_right: assert property (go && i_op == rotate_right_op
		|=> o_alu_flags[1:0] == {$past(i_opnd_a[4]), $past(i_opnd_a[0])}) else $error("rotate");
endmodule : alu_status_flags_monitor
////////////////////////////////
bind alu_status_flags alu_status_flags_monitor mon (.*);

// *** testbench.sv ***
// self-checking bench for the alu status flag block
`timescale 1ns/1ps
module testbench;
	import alu_status_flags_pkg::*;
	logic i_mclk = 1'b0, i_rst = 1'b1, i_exec = 1'b0, i_dest_file = 1'b0, i_extended_set_enable = 1'b0;
	logic o_result_we, o_mode_legal;
	logic [7:0] i_opnd_a = 8'h00, i_opnd_b = 8'h00, i_logic_result = 8'h00, o_alu_flags, o_result;
	logic [11:0] i_dest_addr = alu_flags_addr;
	logic [2:0] i_bit_sel = 3'h0;
	alu_op_t i_op = add_literal_op;
	addr_mode_t i_addr_mode = direct_mode;
	int n_fail = 0, checks = 0;
	alu_status_flags dut (.*);
	initial forever #2 i_mclk = ~i_mclk;
	task cmp(input string n, input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task t(input alu_op_t o, input logic [7:0] a, b, input logic f, x, input addr_mode_t m, input logic [7:0] ef, er);
		logic ok;
		logic rot;
		ok = m != indexed_offset_mode || x;
		rot = o inside {rotate_right_op, rotate_left_op};
		@(posedge i_mclk);
		i_exec <= 1'b1;
		i_op <= o;
		i_opnd_a <= a;
		i_opnd_b <= b;
		i_dest_file <= f;
		i_extended_set_enable <= x;
		i_addr_mode <= m;
		@(posedge i_mclk);
		i_exec <= 1'b0;
		#1;
		// rotates pin down carry and digit carry only
		cmp("flags", ef, rot ? o_alu_flags & 8'h03 : o_alu_flags);
		cmp("strobe", ok && !f, o_result_we);
		cmp("mode", ok, o_mode_legal);
		if (ok && !f && !rot) cmp("result", er, o_result);
		$display("done %s", o.name());
	endtask : t
	task test_done;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done
	initial begin
		#2000;
		n_fail++;
		test_done();
	end
	initial begin
		repeat (16) @(posedge i_mclk);
		i_rst <= 1'b0;
		t(add_literal_op, 8'h7f, 8'h01, 0, 0, direct_mode, 8'h1a, 8'h80);
		t(sub_file_op, 8'h05, 8'h05, 0, 0, direct_mode, 8'h07, 8'h00);
		t(sub_file_op, 8'h00, 8'h01, 0, 0, direct_mode, 8'h10, 8'hff);
		t(add_literal_op, 8'h01, 8'h01, 0, 0, indexed_offset_mode, 8'h10, 8'h00);
		t(file_wipe_op, 8'h00, 8'h00, 1, 0, direct_mode, 8'h14, 8'h00);
		t(add_to_file_op, 8'hff, 8'h01, 1, 0, direct_mode, 8'h07, 8'h00);
		t(rotate_right_op, 8'h11, 8'h00, 0, 0, direct_mode, 8'h03, 8'h00);
		t(rotate_left_op, 8'h08, 8'h00, 0, 0, direct_mode, 8'h02, 8'h00);
		t(add_literal_op, 8'h80, 8'h80, 0, 1, indexed_offset_mode, 8'h0d, 8'h00);
		t(bit_raise_op, 8'h00, 8'h00, 1, 0, direct_mode, 8'h01, 8'h00);
		t(nibble_exchange_op, 8'h21, 8'h00, 1, 0, direct_mode, 8'h12, 8'h00);
		t(logic_op, 8'h00, 8'h00, 0, 0, direct_mode, 8'h06, 8'h00);
		test_done();
	end
endmodule : testbench
